/* File: rtl/rsl_consts.vh */
// constants for the reset, serial rom load and test status block
// Overview of operation
// - reset released after supply good starts the internal reset sequence
// - serial rom clock period is 256 core clock periods
// - each serial rom clock cycle steps the rom to its next bit
// - rom contents arrive one bit at a time on the serial data input
// - device drives active-low rom output enable so the rom drives data
// - test status output is low while system reset is applied
// - test status is forced high at start of cache self-test
// - self-test end clears status on pass, leaves it high on fail
// - timeout reset fires after one billion core cycles without retirement
// - timeout reset gives a 256 core cycle pulse on test status
// - bypass input clocks internal logic from the board clock instead
`ifndef RSL_CONSTS_VH
`define RSL_CONSTS_VH
// ----------------------------------------------------------------
// timing counts, in core clock cycles, and the load length in bits
// ----------------------------------------------------------------
`define RSL_SROM_DIV_LAST 8'hFF
`define RSL_SROM_HALF 8'h80
`define RSL_PULSE_CYCLES 9'h0100
`define RSL_SEQ_CYCLES 8'h40
`define RSL_TIMEOUT_CYCLES 30'h3B9A_CA00
`define RSL_LOAD_BITS 16'h0800
// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
`define RSL_ST_HOLD 2'h0
`define RSL_ST_SEQ 2'h1
`define RSL_ST_LOAD 2'h2
`define RSL_ST_RUN 2'h3
`endif

/* File: rtl/rsl_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module rsl_sync #(
   parameter W = 1
) (
   input wire sys_clk, // core clock
   input wire sys_rst, // async reset, active high
   input wire [W-1:0] d, // asynchronous inputs
   output wire [W-1:0] q // synchronised levels
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta;
         reg sync;
         // first stage feeds only the second
         always @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               meta <= 1'b0;
               sync <= 1'b0;
            end else begin
               meta <= d[i];
               sync <= meta;
            end
         end
         assign q[i] = sync;
      end
   endgenerate
endmodule

/* File: rtl/rsl_srom_shift.v */
// serial rom bit loader with divided rom clock
`timescale 1ns/10ps
`include "rsl_consts.vh"
module rsl_srom_shift #(
   parameter [15:0] LOAD_BITS = `RSL_LOAD_BITS
) (
   input wire sys_clk, // core clock
   input wire sys_rst, // async reset, active high
   input wire tick, // core clock enable
   input wire abort, // drop an unfinished load
   input wire start, // one-cycle start of a load
   input wire din, // synchronised rom data
   output reg rom_clk, // serial rom clock
   output reg rom_oe_n, // rom output enable, active low
   output reg bit_valid, // one-cycle strobe per bit
   output reg bit_data, // received bit
   output reg done // one-cycle end of load
);
   reg active;
   reg [7:0] div;
   reg [15:0] bit_cnt;
   wire period_end = active & tick & (div == `RSL_SROM_DIV_LAST);
   // divider and bit counter; data is taken at the end of each period,
   // long after the rom moved on at the rising edge
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         active <= 1'b0;
         div <= 8'h00;
         bit_cnt <= 16'h0000;
         rom_clk <= 1'b0;
         rom_oe_n <= 1'b1;
         bit_valid <= 1'b0;
         bit_data <= 1'b0;
         done <= 1'b0;
      end else begin
         bit_valid <= 1'b0;
         done <= 1'b0;
         if (abort) begin
            active <= 1'b0;
            div <= 8'h00;
         end else if (start) begin
            active <= 1'b1;
            div <= 8'h00;
            bit_cnt <= 16'h0000;
         end else if (active & tick) begin
            div <= div + 8'h01;
            if (period_end) begin
               bit_valid <= 1'b1;
               bit_data <= din;
               bit_cnt <= bit_cnt + 16'h0001;
               if (bit_cnt == LOAD_BITS - 16'h0001) begin
                  active <= 1'b0;
                  done <= 1'b1;
               end
            end
         end
         // high half of each 256-cycle period steps the rom
         rom_clk <= active & ~abort & (div < `RSL_SROM_HALF);
         rom_oe_n <= ~(active & ~abort);
      end
   end
endmodule

/* File: rtl/rsl_top.v */
// start-up sequencer: power-good reset, serial rom load, test status
`timescale 1ns/10ps
`include "rsl_consts.vh"
module rsl_top #(
   parameter [29:0] TIMEOUT_CYCLES = `RSL_TIMEOUT_CYCLES,
   parameter [15:0] LOAD_BITS = `RSL_LOAD_BITS
) (
   input wire sys_clk, // core clock, 250 MHz
   input wire sys_rst, // async reset, active high
   input wire system_reset_n, // system reset pin, active low
   input wire supply_good, // supply good pin
   input wire board_clock_input, // board clock pin
   input wire clock_source_bypass, // bypass pin
   input wire serial_rom_din, // serial rom data pin
   input wire icache_bist_start, // self-test start pulse
   input wire icache_bist_done, // self-test end pulse
   input wire icache_bist_pass, // self-test result at end
   input wire instr_retired, // retirement pulse
   output reg core_reset, // internal reset, high until load
   output reg core_tick, // core clock enable
   output wire serial_rom_clk, // serial rom clock
   output wire serial_rom_oe_n, // serial rom enable, active low
   output wire boot_bit_valid, // loaded bit strobe
   output wire boot_bit_data, // loaded bit
   output reg boot_done, // load finished, level
   output reg timeout_reset, // timeout event pulse
   output reg reset_order_error, // reset released before supply good
   output reg selftest_status_out // test status pin
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire [4:0] pins_s;
   wire rst_n_s;
   wire good_s;
   wire bclk_s;
   wire bypass_s;
   wire din_s;
   rsl_sync #(
      .W(5)
   ) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .d({system_reset_n, supply_good, board_clock_input,
          clock_source_bypass, serial_rom_din}),
      .q(pins_s)
   );
   assign rst_n_s = pins_s[4];
   assign good_s = pins_s[3];
   assign bclk_s = pins_s[2];
   assign bypass_s = pins_s[1];
   assign din_s = pins_s[0];

   // ----------------------------------------------------------------
   // core clock enable
   // ----------------------------------------------------------------
   reg bclk_d;
   wire bclk_rise = bclk_s & ~bclk_d;
   // with bypass every count runs on board clock edges instead of
   // every core clock, so all timing scales with the board clock
   wire tick = bypass_s ? bclk_rise : 1'b1;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bclk_d <= 1'b0;
         core_tick <= 1'b0;
      end else begin
         bclk_d <= bclk_s;
         core_tick <= tick;
      end
   end

   // ----------------------------------------------------------------
   // power-up ordering
   // ----------------------------------------------------------------
   reg armed;
   // armed only when supply good is seen while reset is still held;
   // a release that comes first is flagged and waited out
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         armed <= 1'b0;
         reset_order_error <= 1'b0;
      end else begin
         if (!good_s)
            armed <= 1'b0;
         else if (!rst_n_s)
            armed <= 1'b1;
         if (rst_n_s && !good_s && !armed)
            reset_order_error <= 1'b1;
         else if (armed)
            reset_order_error <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   reg [1:0] state;
   reg [1:0] next_state;
   reg [7:0] seq_cnt;
   reg [29:0] idle_cnt;
   wire load_done;
   wire held = ~rst_n_s | ~good_s;
   wire seq_end = tick & (seq_cnt == `RSL_SEQ_CYCLES - 8'h01);
   wire timeout_hit = (state == `RSL_ST_RUN) & tick & ~instr_retired &
                      (idle_cnt == TIMEOUT_CYCLES - 30'h0000_0001);
   wire load_start = (state == `RSL_ST_SEQ) & seq_end;

   // next state; reset pin or lost supply wins everywhere
   always @* begin
      next_state = state;
      case (state)
         `RSL_ST_HOLD: begin
            if (rst_n_s && armed)
               next_state = `RSL_ST_SEQ;
         end
         `RSL_ST_SEQ: begin
            if (seq_end)
               next_state = `RSL_ST_LOAD;
         end
         `RSL_ST_LOAD: begin
            if (load_done)
               next_state = `RSL_ST_RUN;
         end
         `RSL_ST_RUN: begin
            if (timeout_hit)
               next_state = `RSL_ST_SEQ;
         end
         default: begin
            next_state = `RSL_ST_HOLD;
         end
      endcase
      if (held)
         next_state = `RSL_ST_HOLD;
   end

   // state and reset sequence counter
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= `RSL_ST_HOLD;
         seq_cnt <= 8'h00;
         core_reset <= 1'b1;
         boot_done <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state != `RSL_ST_SEQ)
            seq_cnt <= 8'h00;
         else if (state == `RSL_ST_SEQ && tick)
            seq_cnt <= seq_cnt + 8'h01;
         core_reset <= (next_state == `RSL_ST_HOLD) ||
                       (next_state == `RSL_ST_SEQ);
         if (next_state == `RSL_ST_HOLD || next_state == `RSL_ST_SEQ)
            boot_done <= 1'b0;
         else if (load_done)
            boot_done <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // serial rom load
   // ----------------------------------------------------------------
   // abort keeps the rom quiet as soon as the part falls back to hold
   rsl_srom_shift #(
      .LOAD_BITS(LOAD_BITS)
   ) u_load (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .abort(held),
      .start(load_start),
      .din(din_s),
      .rom_clk(serial_rom_clk),
      .rom_oe_n(serial_rom_oe_n),
      .bit_valid(boot_bit_valid),
      .bit_data(boot_bit_data),
      .done(load_done)
   );

   // ----------------------------------------------------------------
   // retirement watchdog
   // ----------------------------------------------------------------
   // counts core cycles since the last retirement while running
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         idle_cnt <= 30'h0000_0000;
         timeout_reset <= 1'b0;
      end else begin
         timeout_reset <= timeout_hit;
         if (state != `RSL_ST_RUN || instr_retired || timeout_hit)
            idle_cnt <= 30'h0000_0000;
         else if (tick)
            idle_cnt <= idle_cnt + 30'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // test status
   // ----------------------------------------------------------------
   reg bist_level;
   reg [8:0] pulse_cnt;
   reg next_level;
   // self-test level; start wins over an end in the same cycle
   always @* begin
      next_level = bist_level;
      if (icache_bist_done && !icache_bist_pass)
         next_level = 1'b1;
      else if (icache_bist_done)
         next_level = 1'b0;
      if (icache_bist_start)
         next_level = 1'b1;
      if (state == `RSL_ST_HOLD)
         next_level = 1'b0;
   end

   // timeout pulse rides on top of the self-test level
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bist_level <= 1'b0;
         pulse_cnt <= 9'h000;
         selftest_status_out <= 1'b0;
      end else begin
         bist_level <= next_level;
         if (state == `RSL_ST_HOLD)
            pulse_cnt <= 9'h000;
         else if (timeout_hit)
            pulse_cnt <= `RSL_PULSE_CYCLES;
         else if (pulse_cnt != 9'h000 && tick)
            pulse_cnt <= pulse_cnt - 9'h001;
         selftest_status_out <= (state != `RSL_ST_HOLD) &&
                                (next_level || timeout_hit ||
                                 pulse_cnt > 9'h001 ||
                                 (pulse_cnt == 9'h001 && !tick));
      end
   end
endmodule

/* File: dv/rsl_top_assertions.sv */
// port checker for the start-up sequencer
`timescale 1ns/10ps
module rsl_chk (
   input wire sys_clk, // core clock
   input wire sys_rst, // async reset
   input wire system_reset_n, // reset pin
   input wire clock_source_bypass, // bypass pin
   input wire icache_bist_start, // test start
   input wire icache_bist_done, // test end
   input wire icache_bist_pass, // test result
   input wire core_reset, // internal reset
   input wire serial_rom_clk, // rom clock
   input wire serial_rom_oe_n, // rom enable
   input wire boot_bit_valid, // bit strobe
   input wire timeout_reset, // watchdog pulse
   input wire selftest_status_out // status pin
);
// ----------------------------------------------------------------
// helper counters
// ----------------------------------------------------------------
reg [8:0] rcnt; // cycles since rom clock rose
reg [8:0] pcnt; // cycles into timeout pulse
// rom clock count restarts when idle or bypassed, since ticks then no longer match cycles
always @(posedge sys_clk or posedge sys_rst) begin
   if (sys_rst) begin
      rcnt <= 9'h000;
      pcnt <= 9'h000;
   end else begin
      if (serial_rom_oe_n || clock_source_bypass) rcnt <= 9'h000;
      else if ($rose(serial_rom_clk)) rcnt <= 9'h001;
      else if (rcnt != 9'h000) rcnt <= rcnt + 9'h001;
      if (timeout_reset) pcnt <= 9'h001;
      else if (pcnt != 9'h000 && pcnt != 9'h00FF) pcnt <= pcnt + 9'h001;
      else pcnt <= 9'h000;
   end
end
// ----------------------------------------------------------------
// properties
// ----------------------------------------------------------------
default clocking cb @(posedge sys_clk); endclocking
default disable iff (sys_rst);
// five samples: two synchroniser stages, the state change, then the status register
status_in_rst_a: assert property ((!system_reset_n) [*5] |-> !selftest_status_out)
   else $error("status high in system reset");
bist_start_a: assert property (icache_bist_start && !core_reset && system_reset_n |=>
   selftest_status_out) else $error("status not set by test start");
bist_fail_a: assert property (icache_bist_done && !icache_bist_pass && !core_reset
   && system_reset_n && selftest_status_out |=> selftest_status_out)
   else $error("status dropped on failed test");
bist_pass_a: assert property (icache_bist_done && icache_bist_pass && !icache_bist_start
   && !core_reset && pcnt == 9'h000 && !timeout_reset |=> !selftest_status_out || timeout_reset)
   else $error("status kept on passed test");
timeout_pulse_a: assert property (timeout_reset || pcnt != 9'h000 |-> selftest_status_out)
   else $error("timeout pulse short");
timeout_reload_a: assert property (timeout_reset |-> ##[1:2] core_reset)
   else $error("timeout did not restart");
rom_period_a: assert property ($rose(serial_rom_clk) && rcnt != 9'h000 && !clock_source_bypass
   |-> rcnt == 9'h0100) else $error("rom clock period wrong");
rom_high_a: assert property ($fell(serial_rom_clk) && !serial_rom_oe_n && !clock_source_bypass
   |-> rcnt == 9'h0080) else $error("rom clock high phase wrong");
rom_idle_a: assert property (serial_rom_oe_n |-> !serial_rom_clk)
   else $error("rom clock active while idle");
bit_enabled_a: assert property (boot_bit_valid |-> $past(serial_rom_oe_n) == 1'b0)
   else $error("bit taken with rom disabled");
load_enable_a: assert property ($fell(core_reset) |-> ##[0:4] !serial_rom_oe_n)
   else $error("rom not enabled for load");
endmodule
bind rsl_top rsl_chk rsl_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .system_reset_n(system_reset_n), .clock_source_bypass(clock_source_bypass),
   .icache_bist_start(icache_bist_start), .icache_bist_done(icache_bist_done),
   .icache_bist_pass(icache_bist_pass), .core_reset(core_reset),
   .serial_rom_clk(serial_rom_clk), .serial_rom_oe_n(serial_rom_oe_n),
   .boot_bit_valid(boot_bit_valid), .timeout_reset(timeout_reset),
   .selftest_status_out(selftest_status_out));

/* File: dv/rsl_partner.sv */
// serial rom and system reset model
`timescale 1ns/10ps
module rsl_partner #(
   parameter [15:0] ROM_IMAGE = 16'hA5C3
) (
   input wire sys_clk, // core clock
   input wire power_on, // run a power-up
   input wire early_release, // release reset too soon
   input wire serial_rom_clk, // rom clock
   input wire serial_rom_oe_n, // rom enable
   output reg system_reset_n, // reset pin
   output reg supply_good, // supply good pin
   output wire serial_rom_din // rom data pin
);
reg [3:0] idx; // next bit, msb first
reg last; // bit on the line
initial begin
   system_reset_n = 1'b0;
   supply_good = 1'b0;
   last = 1'b0;
end
// power sequence, pins change on falling core clock
always begin
   @(posedge power_on);
   @(negedge sys_clk);
   repeat (8) @(negedge sys_clk);
   if (early_release) system_reset_n = 1'b1;
   else supply_good = 1'b1;
   repeat (8) @(negedge sys_clk);
   supply_good = 1'b1;
   system_reset_n = 1'b1;
   @(negedge power_on);
   @(negedge sys_clk);
   system_reset_n = 1'b0;
   supply_good = 1'b0;
end
// one bit per rom clock rise, restart when disabled
always @(posedge serial_rom_clk or posedge serial_rom_oe_n) begin
   if (serial_rom_oe_n) idx <= 4'hF;
   else begin
      last <= ROM_IMAGE[idx];
      idx <= idx - 4'h1;
   end
end
// a disabled rom leaves the line, shown as the inverse of the last bit
assign serial_rom_din = serial_rom_oe_n ? ~last : last;
endmodule

/* File: dv/tb_rsl_top.sv */
// testbench for the start-up sequencer
`timescale 1ns/10ps
module tb_rsl_top;
localparam [15:0] ROM_IMAGE = 16'hA5C3;
reg sys_clk, sys_rst, board_clock_input, clock_source_bypass, instr_retired;
reg icache_bist_start, icache_bist_done, icache_bist_pass, power_on, early_release;
wire system_reset_n, supply_good, serial_rom_din, core_reset, core_tick, serial_rom_clk;
wire serial_rom_oe_n, boot_bit_valid, boot_bit_data, boot_done, timeout_reset;
wire reset_order_error, selftest_status_out;
integer miscompares, n_tests, cycles, n, m, i;
rsl_top #(.TIMEOUT_CYCLES(30'h0000_0064), .LOAD_BITS(16'h0004)) rsl_top_inst (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .system_reset_n(system_reset_n),
   .supply_good(supply_good), .board_clock_input(board_clock_input),
   .clock_source_bypass(clock_source_bypass), .serial_rom_din(serial_rom_din),
   .icache_bist_start(icache_bist_start), .icache_bist_done(icache_bist_done),
   .icache_bist_pass(icache_bist_pass), .instr_retired(instr_retired),
   .core_reset(core_reset), .core_tick(core_tick), .serial_rom_clk(serial_rom_clk),
   .serial_rom_oe_n(serial_rom_oe_n), .boot_bit_valid(boot_bit_valid),
   .boot_bit_data(boot_bit_data), .boot_done(boot_done), .timeout_reset(timeout_reset),
   .reset_order_error(reset_order_error), .selftest_status_out(selftest_status_out));
rsl_partner #(.ROM_IMAGE(ROM_IMAGE)) rsl_partner_inst (.sys_clk(sys_clk),
   .power_on(power_on), .early_release(early_release), .serial_rom_clk(serial_rom_clk),
   .serial_rom_oe_n(serial_rom_oe_n), .system_reset_n(system_reset_n),
   .supply_good(supply_good), .serial_rom_din(serial_rom_din));
// clocks: board clock free running, phase unrelated
initial begin
   sys_clk = 1'b0;
   forever #2 sys_clk = ~sys_clk;
end
initial begin
   board_clock_input = 1'b0;
   #1.3;
   forever #16 board_clock_input = ~board_clock_input;
end
task step;
   begin
      @(negedge sys_clk);
   end
endtask
task check(input [15:0] got, input [15:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
endtask
task complete_run;
   begin
      if (miscompares == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   end
endtask
// hang guard
always @(posedge sys_clk) begin
   cycles = cycles + 1;
   if (cycles == 12000) begin
      miscompares = miscompares + 1;
      complete_run;
   end
end
// reset released before supply good must be refused
task t_bad_order;
   begin
      early_release = 1'b1;
      power_on = 1'b1;
      repeat (40) step;
      check({reset_order_error, core_reset}, 2'b11);
      check({serial_rom_oe_n, serial_rom_clk}, 2'b10);
      check(selftest_status_out, 1'b0);
      power_on = 1'b0;
      early_release = 1'b0;
      repeat (4) step;
      sys_rst = 1'b1;
      repeat (2) step;
      sys_rst = 1'b0;
      repeat (4) step;
   end
endtask
// good order, then the rom image arrives bit by bit
task t_boot;
   begin
      power_on = 1'b1;
      n = 0;
      while (core_reset !== 1'b0 && n < 300) begin
         step;
         n = n + 1;
      end
      check(n >= 80 && n <= 92, 1'b1);
      for (i = 0; i < 4; i = i + 1) begin
         n = 0;
         while (boot_bit_valid !== 1'b1 && n < 300) begin
            step;
            n = n + 1;
         end
         check({serial_rom_oe_n, boot_bit_data}, {1'b0, ROM_IMAGE[15 - i]});
         if (i > 0) check(n, 255);
         step;
      end
      repeat (4) step;
      check({boot_done, serial_rom_oe_n, serial_rom_clk}, 3'b110);
   end
endtask
// failed test keeps status, passed test clears it
task t_bist;
   begin
      instr_retired = 1'b1;
      icache_bist_start = 1'b1;
      step;
      instr_retired = 1'b0;
      icache_bist_start = 1'b0;
      step;
      check(selftest_status_out, 1'b1);
      icache_bist_done = 1'b1;
      step;
      icache_bist_done = 1'b0;
      step;
      check(selftest_status_out, 1'b1);
      icache_bist_start = 1'b1;
      step;
      icache_bist_start = 1'b0;
      icache_bist_done = 1'b1;
      icache_bist_pass = 1'b1;
      step;
      icache_bist_done = 1'b0;
      icache_bist_pass = 1'b0;
      step;
      check(selftest_status_out, 1'b0);
   end
endtask
// retirements hold the watchdog off; silence makes it fire
task t_timeout;
   begin
      m = 0;
      for (n = 0; n < 300; n = n + 1) begin
         instr_retired = (n % 40 == 0);
         if (timeout_reset === 1'b1) m = 1;
         step;
      end
      check(m, 0);
      instr_retired = 1'b1;
      step;
      instr_retired = 1'b0;
      n = 0;
      while (timeout_reset !== 1'b1 && n < 300) begin
         step;
         n = n + 1;
      end
      check(n >= 96 && n <= 104, 1'b1);
      m = 0;
      while (selftest_status_out === 1'b1 && m < 400) begin
         step;
         m = m + 1;
      end
      check(m, 256);
      n = 0;
      while (boot_done !== 1'b1 && n < 2000) begin
         step;
         n = n + 1;
      end
      check(boot_done, 1'b1);
   end
endtask
// dropping the reset pin while status is high must clear it
task t_drop;
   begin
      icache_bist_start = 1'b1;
      step;
      icache_bist_start = 1'b0;
      check(selftest_status_out, 1'b1);
      power_on = 1'b0;
      repeat (8) step;
      check(selftest_status_out, 1'b0);
      check({core_reset, serial_rom_oe_n, serial_rom_clk}, 3'b110);
   end
endtask
// bypass: ticks follow board clock rises, one per 8 core cycles
task t_bypass;
   begin
      instr_retired = 1'b1;
      clock_source_bypass = 1'b1;
      step;
      instr_retired = 1'b0;
      repeat (4) step;
      m = 0;
      for (n = 0; n < 320; n = n + 1) begin
         if (core_tick === 1'b1) m = m + 1;
         step;
      end
      check(m >= 39 && m <= 41, 1'b1);
      clock_source_bypass = 1'b0;
   end
endtask
initial begin
   {sys_rst, clock_source_bypass, instr_retired, power_on, early_release} = 5'h10;
   {icache_bist_start, icache_bist_done, icache_bist_pass} = 3'h0;
   miscompares = 0;
   n_tests = 0;
   cycles = 0;
   repeat (8) @(posedge sys_clk);
   step;
   sys_rst = 1'b0;
   t_bad_order;
   t_boot;
   t_bist;
   t_timeout;
   t_drop;
   t_bypass;
   complete_run;
end
endmodule
